//--- inc/cloc_pkg.sv
// shared constants and types for the camera output line control block
package cloc_pkg;

   // structure
   localparam int NLINE  = 4;
   localparam int SEL_W  = 2;
   localparam int CNT_W  = 12;
   localparam int BASE_W = 8;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // timing
   localparam int CLK_HZ  = 100_000_000;
   localparam int TICK_US = 1;
   localparam int US_CYC  = (CLK_HZ / 1_000_000) * TICK_US;
   localparam int PRE_W   = 8;

   // register byte addresses
   localparam logic [ADDR_W-1:0] A_LINE_SEL  = 8'h00;
   localparam logic [ADDR_W-1:0] A_LINE_SRC  = 8'h04;
   localparam logic [ADDR_W-1:0] A_LINE_INV  = 8'h08;
   localparam logic [ADDR_W-1:0] A_USER_SEL  = 8'h0c;
   localparam logic [ADDR_W-1:0] A_USER_VAL  = 8'h10;
   localparam logic [ADDR_W-1:0] A_USER_ALL  = 8'h14;
   localparam logic [ADDR_W-1:0] A_ACQ_MODE  = 8'h18;
   localparam logic [ADDR_W-1:0] A_TMR_SEL   = 8'h1c;
   localparam logic [ADDR_W-1:0] A_TMR_DLY   = 8'h20;
   localparam logic [ADDR_W-1:0] A_TMR_WID   = 8'h24;
   localparam logic [ADDR_W-1:0] A_DLY_BASE  = 8'h28;
   localparam logic [ADDR_W-1:0] A_WID_BASE  = 8'h2c;
   localparam logic [ADDR_W-1:0] A_LEVELS    = 8'h30;

   // reset values and limits
   localparam logic [CNT_W-1:0]  DLY_RST  = 12'h000;
   localparam logic [CNT_W-1:0]  WID_RST  = 12'h001;
   localparam logic [CNT_W-1:0]  CNT_ONE  = 12'h001;
   localparam logic [CNT_W-1:0]  CNT_ZERO = 12'h000;
   localparam logic [BASE_W-1:0] BASE_RST = 8'h01;
   localparam logic [BASE_W-1:0] BASE_ZERO = 8'h00;
   localparam logic [SEL_W-1:0]  SEL_RST  = 2'h0;
   localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

   // line sources; the timer code means the line's own timer
   typedef enum logic [2:0] {
      SRC_ACQ_WAIT,
      SRC_TRIG_RDY,
      SRC_EXP_ACT,
      SRC_TIMER,
      SRC_USER
   } cloc_src_t;

   // timer states
   typedef enum logic [1:0] {
      T_IDLE,
      T_DELAY,
      T_HIGH
   } cloc_tst_t;

endpackage : cloc_pkg

//--- hw/cloc_timer.sv
// one delay and pulse timer
`timescale 1ns/1ns
module cloc_timer
#(
   parameter int CNT_W = cloc_pkg::CNT_W
)
(
   // clock and reset
   input  wire logic             mclk_in,
   input  wire logic             rst_b_in,
   // start and ticks
   input  wire logic             start_in,
   input  wire logic             dly_tick_in,
   input  wire logic             wid_tick_in,
   // settings
   input  wire logic [CNT_W-1:0] delay_in,
   input  wire logic [CNT_W-1:0] width_in,
   // timer level
   output logic                  level_out
);

   cloc_pkg::cloc_tst_t state_r;
   cloc_pkg::cloc_tst_t state_nxt;
   logic [CNT_W-1:0]    cnt_r;
   logic [CNT_W-1:0]    cnt_nxt;
   logic                lvl_r;
   logic                lvl_nxt;

   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      unique case (state_r)
         cloc_pkg::T_IDLE:
            if (start_in) // RL10
            begin
               if (delay_in == cloc_pkg::CNT_ZERO) // RL15
               begin
                  state_nxt = cloc_pkg::T_HIGH;
                  cnt_nxt   = width_in;
               end
               else
               begin
                  state_nxt = cloc_pkg::T_DELAY;
                  cnt_nxt   = delay_in;
               end
            end
         cloc_pkg::T_DELAY:
            if (dly_tick_in) // RL15
            begin
               if (cnt_r <= cloc_pkg::CNT_ONE) // RL10
               begin
                  state_nxt = cloc_pkg::T_HIGH;
                  cnt_nxt   = width_in;
               end
               else
                  cnt_nxt = cnt_r - cloc_pkg::CNT_ONE;
            end
         cloc_pkg::T_HIGH:
            if (wid_tick_in) // RL16
            begin
               if (cnt_r <= cloc_pkg::CNT_ONE) // RL11
                  state_nxt = cloc_pkg::T_IDLE;
               else
                  cnt_nxt = cnt_r - cloc_pkg::CNT_ONE;
            end
      endcase
      lvl_nxt = (state_nxt == cloc_pkg::T_HIGH); // RL18
   end

   always_ff @(posedge mclk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         state_r <= cloc_pkg::T_IDLE;
         cnt_r   <= cloc_pkg::CNT_ZERO;
         lvl_r   <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         lvl_r   <= lvl_nxt;
      end
   end

   assign level_out = lvl_r;

   // checks
   sequence s_idle_start;
      state_r == cloc_pkg::T_IDLE && start_in;
   endsequence

   property p_delay_first;
      @(posedge mclk_in) disable iff (!rst_b_in)
      s_idle_start and (delay_in != cloc_pkg::CNT_ZERO) ##0 !dly_tick_in |=> !level_out;
   endproperty
   a_delay_first : assert property (p_delay_first) // RL10
      else $error("timer went high before delay");

   property p_zero_delay;
      @(posedge mclk_in) disable iff (!rst_b_in)
      s_idle_start and (delay_in == cloc_pkg::CNT_ZERO) |=> level_out;
   endproperty
   a_zero_delay : assert property (p_zero_delay) // RL15
      else $error("zero delay did not go high at once");

   property p_width_end;
      @(posedge mclk_in) disable iff (!rst_b_in)
      state_r == cloc_pkg::T_HIGH && wid_tick_in && cnt_r == cloc_pkg::CNT_ONE
      |=> !level_out && state_r == cloc_pkg::T_IDLE;
   endproperty
   a_width_end : assert property (p_width_end) // RL11
      else $error("timer did not fall at width end");

   property p_ignore_start;
      @(posedge mclk_in) disable iff (!rst_b_in)
      state_r == cloc_pkg::T_DELAY && start_in && !dly_tick_in
      |=> state_r == cloc_pkg::T_DELAY && $stable(cnt_r);
   endproperty
   a_ignore_start : assert property (p_ignore_start) // RL18
      else $error("start restarted a running timer");

   property p_idle_low;
      @(posedge mclk_in) disable iff (!rst_b_in)
      state_r == cloc_pkg::T_IDLE && !start_in |=> !level_out;
   endproperty
   a_idle_low : assert property (p_idle_low) // RL18
      else $error("idle timer output high");

endmodule : cloc_timer

//--- hw/cloc_top.sv
// camera output line control: source select, inverters, soft levels, timers, apb
// What this block does
// RL1: each line picks status, timer or soft source
// RL2: line index selects line for source/invert
// RL3: trigger-wait source only in standard mode
// RL4: reset: exposure line 1, ready line 2
// RL5: soft source drives written, readable level
// RL6: soft output index n sets line n
// RL7: 32-bit vector, low four bits set all
// RL8: per-line inverter complements selected source
// RL9: soft level applied before the inverter
// RL10: start runs delay, then output goes high
// RL11: output falls when width elapses
// RL12: exposure start is the only start event
// RL13: timer n reaches only line n
// RL14: software inverts line for high-during-delay
// RL15: delay is count 0..4095 times tick
// RL16: width is count 1..4095 times tick
// RL17: one delay tick shared by all timers
// RL18: idle timer low; starts ignored while active
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ns
module cloc_top
#(
   parameter int NLINE  = cloc_pkg::NLINE,
   parameter int CNT_W  = cloc_pkg::CNT_W,
   parameter int BASE_W = cloc_pkg::BASE_W
)
(
   // clock and reset
   input  wire logic                        mclk_in,
   input  wire logic                        rst_b_in,
   // apb slave
   input  wire logic                        psel_in,
   input  wire logic                        penable_in,
   input  wire logic                        pwrite_in,
   input  wire logic [cloc_pkg::ADDR_W-1:0] paddr_in,
   input  wire logic [cloc_pkg::DATA_W-1:0] pwdata_in,
   output logic      [cloc_pkg::DATA_W-1:0] prdata_out,
   output logic                             pready_out,
   output logic                             pslverr_out,
   // status signals
   input  wire logic                        acq_wait_in,
   input  wire logic                        trig_rdy_in,
   input  wire logic                        exp_act_in,
   // output lines
   output logic      [NLINE-1:0]            line_out
);

   localparam int SW = cloc_pkg::SEL_W;
   localparam int DW = cloc_pkg::DATA_W;

   // register state
   logic [SW-1:0]       line_sel_r, line_sel_nxt;
   cloc_pkg::cloc_src_t src_r [NLINE];
   cloc_pkg::cloc_src_t src_nxt [NLINE];
   logic [NLINE-1:0]    inv_r, inv_nxt;
   logic [SW-1:0]       user_sel_r, user_sel_nxt;
   logic [NLINE-1:0]    user_r, user_nxt;
   logic                std_r, std_nxt;
   logic [SW-1:0]       tmr_sel_r, tmr_sel_nxt;
   logic [CNT_W-1:0]    dly_r [NLINE];
   logic [CNT_W-1:0]    dly_nxt [NLINE];
   logic [CNT_W-1:0]    wid_r [NLINE];
   logic [CNT_W-1:0]    wid_nxt [NLINE];
   logic [BASE_W-1:0]   dbase_r, dbase_nxt;
   logic [BASE_W-1:0]   wbase_r, wbase_nxt;
   // bus answer
   logic [DW-1:0]       prdata_r, prdata_nxt;
   logic                pready_r, pready_nxt;
   logic                pslverr_r, pslverr_nxt;
   logic                wr_en;
   // ticks, start, lines
   logic [cloc_pkg::PRE_W-1:0] us_cnt_r, us_cnt_nxt;
   logic                us_tick;
   logic [BASE_W-1:0]   dcnt_r, dcnt_nxt, wcnt_r, wcnt_nxt;
   logic                dly_tick_r, dly_tick_nxt, wid_tick_r, wid_tick_nxt;
   logic                exp_d_r;
   logic                start;
   logic [NLINE-1:0]    tmr_lvl;
   logic [NLINE-1:0]    line_r, line_nxt;

   // selected source level, before the inverter
   function automatic logic src_level(input cloc_pkg::cloc_src_t s, input logic std,
                                      input logic aw, input logic tr, input logic ex,
                                      input logic tm, input logic us);
      logic v;
      v = 1'b0;
      unique case (s)
         cloc_pkg::SRC_ACQ_WAIT: v = aw & std; // RL3
         cloc_pkg::SRC_TRIG_RDY: v = tr;
         cloc_pkg::SRC_EXP_ACT:  v = ex;
         cloc_pkg::SRC_TIMER:    v = tm; // RL13
         cloc_pkg::SRC_USER:     v = us; // RL5
      endcase
      return v;
   endfunction : src_level

   function automatic logic [DW-1:0] zext(input logic [CNT_W-1:0] v);
      return {{(DW-CNT_W){1'b0}}, v};
   endfunction : zext

   // apb decode and register writes
   assign wr_en = psel_in & penable_in & pwrite_in & pready_r;

   always_comb
   begin
      line_sel_nxt = line_sel_r;
      src_nxt      = src_r;
      inv_nxt      = inv_r;
      user_sel_nxt = user_sel_r;
      user_nxt     = user_r;
      std_nxt      = std_r;
      tmr_sel_nxt  = tmr_sel_r;
      dly_nxt      = dly_r;
      wid_nxt      = wid_r;
      dbase_nxt    = dbase_r;
      wbase_nxt    = wbase_r;
      if (wr_en)
      begin
         case (paddr_in)
            cloc_pkg::A_LINE_SEL: line_sel_nxt = pwdata_in[SW-1:0]; // RL2
            cloc_pkg::A_LINE_SRC:
               if (pwdata_in[2:0] <= cloc_pkg::SRC_USER &&
                   !(pwdata_in[2:0] == cloc_pkg::SRC_ACQ_WAIT && !std_r)) // RL3
                  src_nxt[line_sel_r] = cloc_pkg::cloc_src_t'(pwdata_in[2:0]); // RL1
            cloc_pkg::A_LINE_INV: inv_nxt[line_sel_r] = pwdata_in[0]; // RL8
            cloc_pkg::A_USER_SEL: user_sel_nxt = pwdata_in[SW-1:0];
            cloc_pkg::A_USER_VAL: user_nxt[user_sel_r] = pwdata_in[0]; // RL6
            cloc_pkg::A_USER_ALL: user_nxt = pwdata_in[NLINE-1:0]; // RL7
            cloc_pkg::A_ACQ_MODE: std_nxt = pwdata_in[0];
            cloc_pkg::A_TMR_SEL:  tmr_sel_nxt = pwdata_in[SW-1:0];
            cloc_pkg::A_TMR_DLY:  dly_nxt[tmr_sel_r] = pwdata_in[CNT_W-1:0]; // RL15
            cloc_pkg::A_TMR_WID:
               if (pwdata_in[CNT_W-1:0] != cloc_pkg::CNT_ZERO) // RL16
                  wid_nxt[tmr_sel_r] = pwdata_in[CNT_W-1:0];
            cloc_pkg::A_DLY_BASE:
               if (pwdata_in[BASE_W-1:0] != cloc_pkg::BASE_ZERO) // RL17
                  dbase_nxt = pwdata_in[BASE_W-1:0];
            cloc_pkg::A_WID_BASE:
               if (pwdata_in[BASE_W-1:0] != cloc_pkg::BASE_ZERO)
                  wbase_nxt = pwdata_in[BASE_W-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         line_sel_r <= cloc_pkg::SEL_RST;
         src_r[0]   <= cloc_pkg::SRC_EXP_ACT; // RL4
         src_r[1]   <= cloc_pkg::SRC_TRIG_RDY; // RL4
         for (int i = 2; i < NLINE; i++)
            src_r[i] <= cloc_pkg::SRC_USER;
         inv_r      <= '0;
         user_sel_r <= cloc_pkg::SEL_RST;
         user_r     <= '0;
         std_r      <= 1'b1;
         tmr_sel_r  <= cloc_pkg::SEL_RST;
         for (int i = 0; i < NLINE; i++)
         begin
            dly_r[i] <= cloc_pkg::DLY_RST;
            wid_r[i] <= cloc_pkg::WID_RST;
         end
         dbase_r    <= cloc_pkg::BASE_RST;
         wbase_r    <= cloc_pkg::BASE_RST;
      end
      else
      begin
         line_sel_r <= line_sel_nxt;
         src_r      <= src_nxt;
         inv_r      <= inv_nxt;
         user_sel_r <= user_sel_nxt;
         user_r     <= user_nxt;
         std_r      <= std_nxt;
         tmr_sel_r  <= tmr_sel_nxt;
         dly_r      <= dly_nxt;
         wid_r      <= wid_nxt;
         dbase_r    <= dbase_nxt;
         wbase_r    <= wbase_nxt;
      end
   end

   // apb answer: one wait state, data prepared in the first access cycle
   always_comb
   begin
      pready_nxt  = psel_in & penable_in & ~pready_r;
      prdata_nxt  = cloc_pkg::DATA_ZERO;
      pslverr_nxt = 1'b0;
      if (pready_nxt)
      begin
         case (paddr_in)
            cloc_pkg::A_LINE_SEL: prdata_nxt[SW-1:0] = line_sel_r;
            cloc_pkg::A_LINE_SRC: prdata_nxt[2:0] = src_r[line_sel_r];
            cloc_pkg::A_LINE_INV: prdata_nxt[0] = inv_r[line_sel_r];
            cloc_pkg::A_USER_SEL: prdata_nxt[SW-1:0] = user_sel_r;
            cloc_pkg::A_USER_VAL: prdata_nxt[0] = user_r[user_sel_r]; // RL5
            cloc_pkg::A_USER_ALL: prdata_nxt[NLINE-1:0] = user_r; // RL7
            cloc_pkg::A_ACQ_MODE: prdata_nxt[0] = std_r;
            cloc_pkg::A_TMR_SEL:  prdata_nxt[SW-1:0] = tmr_sel_r;
            cloc_pkg::A_TMR_DLY:  prdata_nxt = zext(dly_r[tmr_sel_r]);
            cloc_pkg::A_TMR_WID:  prdata_nxt = zext(wid_r[tmr_sel_r]);
            cloc_pkg::A_DLY_BASE: prdata_nxt[BASE_W-1:0] = dbase_r;
            cloc_pkg::A_WID_BASE: prdata_nxt[BASE_W-1:0] = wbase_r;
            cloc_pkg::A_LEVELS:   prdata_nxt[2*NLINE-1:0] = {tmr_lvl, line_r};
            default:              pslverr_nxt = 1'b1;
         endcase
      end
   end

   always_ff @(posedge mclk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         prdata_r  <= cloc_pkg::DATA_ZERO;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end
      else
      begin
         prdata_r  <= prdata_nxt;
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   // 1 us divider and shared delay and width ticks
   assign us_tick = (us_cnt_r == cloc_pkg::PRE_W'(cloc_pkg::US_CYC - 1));

   always_comb
   begin
      us_cnt_nxt   = us_tick ? '0 : us_cnt_r + 1'b1;
      dcnt_nxt     = dcnt_r;
      wcnt_nxt     = wcnt_r;
      dly_tick_nxt = 1'b0;
      wid_tick_nxt = 1'b0;
      if (us_tick)
      begin
         dly_tick_nxt = (dcnt_r + 1'b1 >= dbase_r); // RL17
         dcnt_nxt     = dly_tick_nxt ? '0 : dcnt_r + 1'b1;
         wid_tick_nxt = (wcnt_r + 1'b1 >= wbase_r);
         wcnt_nxt     = wid_tick_nxt ? '0 : wcnt_r + 1'b1;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
      begin
         us_cnt_r   <= '0;
         dcnt_r     <= '0;
         wcnt_r     <= '0;
         dly_tick_r <= 1'b0;
         wid_tick_r <= 1'b0;
         exp_d_r    <= 1'b0;
      end
      else
      begin
         us_cnt_r   <= us_cnt_nxt;
         dcnt_r     <= dcnt_nxt;
         wcnt_r     <= wcnt_nxt;
         dly_tick_r <= dly_tick_nxt;
         wid_tick_r <= wid_tick_nxt;
         exp_d_r    <= exp_act_in;
      end
   end

   // exposure start is the one start event
   assign start = exp_act_in & ~exp_d_r; // RL12

   for (genvar g = 0; g < NLINE; g++)
   begin : g_tmr
      cloc_timer #(.CNT_W(CNT_W)) u_tmr (
         .mclk_in     (mclk_in),
         .rst_b_in    (rst_b_in),
         .start_in    (start),
         .dly_tick_in (dly_tick_r),
         .wid_tick_in (wid_tick_r),
         .delay_in    (dly_r[g]),
         .width_in    (wid_r[g]),
         .level_out   (tmr_lvl[g])
      );
   end

   // line mux, soft level first, inverter last
   always_comb
   begin
      for (int i = 0; i < NLINE; i++)
         line_nxt[i] = src_level(src_r[i], std_r, acq_wait_in, trig_rdy_in, exp_act_in,
                                 tmr_lvl[i], user_r[i]) ^ inv_r[i]; // RL9
   end

   always_ff @(posedge mclk_in or negedge rst_b_in)
   begin
      if (!rst_b_in)
         line_r <= '0;
      else
         line_r <= line_nxt; // RL8
   end

   assign line_out    = line_r;
   assign prdata_out  = prdata_r;
   assign pready_out  = pready_r;
   assign pslverr_out = pslverr_r;

   // checks
   property p_reset_map;
      @(posedge mclk_in) disable iff (!rst_b_in)
      $rose(rst_b_in) |-> src_r[0] == cloc_pkg::SRC_EXP_ACT && src_r[1] == cloc_pkg::SRC_TRIG_RDY;
   endproperty
   a_reset_map : assert property (p_reset_map) // RL4
      else $error("reset line sources wrong");

   property p_user_all;
      @(posedge mclk_in) disable iff (!rst_b_in)
      wr_en && paddr_in == cloc_pkg::A_USER_ALL |=> user_r == $past(pwdata_in[NLINE-1:0]);
   endproperty
   a_user_all : assert property (p_user_all) // RL7
      else $error("vector write lost");

   property p_user_one;
      @(posedge mclk_in) disable iff (!rst_b_in)
      wr_en && paddr_in == cloc_pkg::A_USER_VAL |=> user_r[$past(user_sel_r)] == $past(pwdata_in[0]);
   endproperty
   a_user_one : assert property (p_user_one) // RL6
      else $error("indexed soft write lost");

   property p_legacy_refuse;
      @(posedge mclk_in) disable iff (!rst_b_in)
      wr_en && paddr_in == cloc_pkg::A_LINE_SRC && !std_r &&
      pwdata_in[2:0] == cloc_pkg::SRC_ACQ_WAIT
      |=> src_r[$past(line_sel_r)] == $past(src_r[line_sel_r]);
   endproperty
   a_legacy_refuse : assert property (p_legacy_refuse) // RL3
      else $error("trigger wait accepted in legacy mode");

   property p_pready_pulse;
      @(posedge mclk_in) disable iff (!rst_b_in)
      psel_in && penable_in && !pready_r |=> pready_r ##1 !pready_r;
   endproperty
   a_pready_pulse : assert property (p_pready_pulse) // local apb timing
      else $error("apb answer not one cycle");

   for (genvar k = 0; k < NLINE; k++)
   begin : g_chk
      sequence s_user_steady;
         src_r[k] == cloc_pkg::SRC_USER ##1 src_r[k] == cloc_pkg::SRC_USER;
      endsequence

      property p_user_inv;
         @(posedge mclk_in) disable iff (!rst_b_in)
         s_user_steady |-> line_out[k] == ($past(user_r[k]) ^ $past(inv_r[k]));
      endproperty
      a_user_inv : assert property (p_user_inv) // RL9
         else $error("soft line level wrong");

      property p_timer_route;
         @(posedge mclk_in) disable iff (!rst_b_in)
         src_r[k] == cloc_pkg::SRC_TIMER |=> line_out[k] == ($past(tmr_lvl[k]) ^ $past(inv_r[k]));
      endproperty
      a_timer_route : assert property (p_timer_route) // RL13
         else $error("timer not on its own line");

      property p_exp_inv;
         @(posedge mclk_in) disable iff (!rst_b_in)
         src_r[k] == cloc_pkg::SRC_EXP_ACT |=> line_out[k] == ($past(exp_act_in) ^ $past(inv_r[k]));
      endproperty
      a_exp_inv : assert property (p_exp_inv) // RL8
         else $error("inverter not applied");
   end

endmodule : cloc_top

//--- bench/cloc_far_model.sv
// far-side load model: counts pulses and measures high time per line
`timescale 1ns/1ns
module cloc_far_model
(
   // clock
   input  wire logic             mclk_in,
   // watched lines
   input  wire logic [3:0]       line_in,
   // measurements
   output logic      [3:0][7:0]  rises_out,
   output logic      [3:0][15:0] hi_len_out
);
   logic [3:0]       prev_r;
   logic [3:0][15:0] run_r;

   initial
   begin
      prev_r     = 4'h0;
      run_r      = '0;
      rises_out  = '0;
      hi_len_out = '0;
   end

   // passive opto load: samples only, never drives
   always @(posedge mclk_in)
   begin
      for (int i = 0; i < 4; i++)
      begin
         if (line_in[i] === 1'b1 && !prev_r[i])
            rises_out[i] <= rises_out[i] + 8'h01;
         run_r[i] <= (line_in[i] === 1'b1) ? run_r[i] + 16'h0001 : 16'h0000;
         if (line_in[i] !== 1'b1 && prev_r[i])
            hi_len_out[i] <= run_r[i];
      end
      prev_r <= line_in;
   end
endmodule : cloc_far_model

//--- bench/cloc_tb_top.sv
// self-checking bench for the camera output line control block
`timescale 1ns/1ns
module cloc_tb_top;
   logic             mclk_in     = 1'b0;
   logic             rst_b_in    = 1'b0;
   logic             psel_in     = 1'b0;
   logic             penable_in  = 1'b0;
   logic             pwrite_in   = 1'b0;
   logic [7:0]       paddr_in    = 8'h00;
   logic [31:0]      pwdata_in   = 32'h0000_0000;
   logic             acq_wait_in = 1'b0;
   logic             trig_rdy_in = 1'b0;
   logic             exp_act_in  = 1'b0;
   logic [31:0]      prdata_out;
   logic             pready_out;
   logic             pslverr_out;
   logic [3:0]       line_out;
   logic [3:0][7:0]  rises;
   logic [3:0][15:0] hi_len;
   int               mismatches  = 0;
   int               comparisons = 0;
   int               cyc         = 0;

   cloc_top uut (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
      .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
      .pslverr_out(pslverr_out), .acq_wait_in(acq_wait_in), .trig_rdy_in(trig_rdy_in),
      .exp_act_in(exp_act_in), .line_out(line_out));

   cloc_far_model far (.mclk_in(mclk_in), .line_in(line_out), .rises_out(rises),
      .hi_len_out(hi_len));

   always #5 mclk_in = ~mclk_in;

   // hang guard
   always @(posedge mclk_in)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         mismatches++;
         end_sim();
      end
   end

   task end_sim();
      if (mismatches == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_sim

   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task chk_rng(input string n, input int lo, input int hi, input int g);
      comparisons++;
      if (g < lo || g > hi)
      begin
         mismatches++;
         $display("wrong value %s expected %0d..%0d seen %0d", n, lo, hi, g);
      end
   endtask : chk_rng

   task tick(input int n);
      repeat (n) @(posedge mclk_in);
   endtask : tick

   // one apb transfer, held until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
      psel_in    <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in  <= w;
      paddr_in   <= a;
      pwdata_in  <= d;
      @(posedge mclk_in);
      penable_in <= 1'b1;
      @(posedge mclk_in);
      while (pready_out !== 1'b1)
         @(posedge mclk_in);
      q = prdata_out;
      e = pslverr_out;
      psel_in    <= 1'b0;
      penable_in <= 1'b0;
      @(posedge mclk_in);
   endtask : apb

   task wreg(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask : wreg

   task rchk(input string n, input logic [7:0] a, input logic [31:0] x);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, q, e);
      chk(n, x, q);
   endtask : rchk

   task t_reset_map();
      exp_act_in  <= 1'b1;
      trig_rdy_in <= 1'b0;
      tick(3);
      chk("lines 1 2 after reset", 32'h0000_0001, {30'h0, line_out[1:0]});
      rchk("line1 source", cloc_pkg::A_LINE_SRC, 32'h0000_0002);
      wreg(cloc_pkg::A_LINE_SEL, 32'h0000_0001);
      rchk("line2 source", cloc_pkg::A_LINE_SRC, 32'h0000_0001);
      exp_act_in <= 1'b0;
   endtask : t_reset_map

   task t_soft();
      wreg(cloc_pkg::A_USER_SEL, 32'h0000_0002);
      wreg(cloc_pkg::A_USER_VAL, 32'h0000_0001);
      tick(2);
      chk("soft line3", 32'h0000_0001, {31'h0, line_out[2]});
      rchk("soft value", cloc_pkg::A_USER_VAL, 32'h0000_0001);
      wreg(cloc_pkg::A_USER_ALL, 32'hFFFF_FFFA);
      tick(2);
      chk("soft lines 3 4", 32'h0000_0002, {30'h0, line_out[3:2]});
      rchk("soft vector", cloc_pkg::A_USER_ALL, 32'h0000_000A);
      wreg(cloc_pkg::A_LINE_SEL, 32'h0000_0003);
      wreg(cloc_pkg::A_LINE_INV, 32'h0000_0001);
      tick(2);
      chk("inverted soft line4", 32'h0000_0000, {31'h0, line_out[3]});
      wreg(cloc_pkg::A_LINE_INV, 32'h0000_0000);
   endtask : t_soft

   task t_mode();
      acq_wait_in <= 1'b1;
      wreg(cloc_pkg::A_LINE_SEL, 32'h0000_0000);
      wreg(cloc_pkg::A_LINE_SRC, 32'h0000_0000);
      tick(2);
      chk("wait source standard", 32'h0000_0001, {31'h0, line_out[0]});
      wreg(cloc_pkg::A_ACQ_MODE, 32'h0000_0000);
      tick(2);
      chk("wait source legacy", 32'h0000_0000, {31'h0, line_out[0]});
      wreg(cloc_pkg::A_LINE_SEL, 32'h0000_0001);
      wreg(cloc_pkg::A_LINE_SRC, 32'h0000_0000);
      rchk("legacy refused", cloc_pkg::A_LINE_SRC, 32'h0000_0001);
      wreg(cloc_pkg::A_ACQ_MODE, 32'h0000_0001);
      acq_wait_in <= 1'b0;
   endtask : t_mode

   task t_timer();
      logic [7:0] r0;
      int         n;
      wreg(cloc_pkg::A_LINE_SEL, 32'h0000_0003);
      wreg(cloc_pkg::A_LINE_SRC, 32'h0000_0003);
      wreg(cloc_pkg::A_TMR_SEL, 32'h0000_0003);
      wreg(cloc_pkg::A_TMR_DLY, 32'h0000_0002);
      wreg(cloc_pkg::A_TMR_WID, 32'h0000_0003);
      tick(2);
      r0 = rises[3];
      n  = 0;
      exp_act_in <= 1'b1;
      tick(3);
      exp_act_in <= 1'b0;
      tick(3);
      exp_act_in <= 1'b1; // second start inside delay
      while (line_out[3] !== 1'b1 && n < 1000)
      begin
         @(posedge mclk_in);
         n++;
      end
      chk_rng("delay cycles", 104, 203, n + 6);
      chk("line1 idle", 32'h0000_0000, {31'h0, line_out[0]});
      tick(400);
      exp_act_in <= 1'b0;
      chk("pulse count", 32'h0000_0001, {24'h0, rises[3] - r0});
      chk_rng("width cycles", 200, 302, int'(hi_len[3]));
      wreg(cloc_pkg::A_LINE_INV, 32'h0000_0001);
      exp_act_in <= 1'b1;
      tick(20);
      chk("inverted delay level", 32'h0000_0001, {31'h0, line_out[3]});
      exp_act_in <= 1'b0;
   endtask : t_timer

   task t_unmapped();
      logic [31:0] q;
      logic        e;
      apb(1'b0, 8'h3c, 32'h0000_0000, q, e);
      chk("unmapped data", 32'h0000_0000, q);
      chk("unmapped error", 32'h0000_0001, {31'h0, e});
      wreg(cloc_pkg::A_DLY_BASE, 32'h0000_0000);
      rchk("delay tick kept", cloc_pkg::A_DLY_BASE, 32'h0000_0001);
   endtask : t_unmapped

   initial
   begin
      tick(2);
      rst_b_in <= 1'b1;
      @(posedge mclk_in);
      t_reset_map();
      t_soft();
      t_mode();
      t_timer();
      t_unmapped();
      end_sim();
   end
endmodule : cloc_tb_top
